// >>> ciefb_core.sv
// core interrupt enable and flag bits: holds the control byte, sets the
// timer, external pin and port change flags, and drives the request.
// assumes timer_overflow and ctl_wr come from logic on clk; pins do not.
`timescale 1ns/1ns
`include "ciefb_cfg.svh"
module ciefb_core import ciefb_pkg::*; #(
  parameter int PORT_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control byte write from the core, one-cycle strobe
  input wire logic ctl_wr,
  input wire logic [7:0] ctl_wdata,
  // control byte read back
  output logic [7:0] ctl_rdata,
  // timer event, one-cycle pulse on clk
  input wire logic timer_overflow,
  // external interrupt pin and its edge choice
  input wire logic ext_pin,
  input wire logic ext_edge_rising,
  // change sense port and per-pin enables
  input wire logic [PORT_W-1:0] change_sense_port,
  input wire logic [PORT_W-1:0] pin_change_enable_mask,
  // flags and request
  output logic timer_overflow_flag,
  output logic ext_pin_irq_flag,
  output logic port_change_flag,
  output logic irq_req
);

  ciefb_evt_if #(.PORT_W(PORT_W)) evt ();

  assign evt.edge_rising = ext_edge_rising;
  assign evt.change_mask = pin_change_enable_mask;

  ciefb_sense #(.PORT_W(PORT_W)) u_sense (
    .clk(clk),
    .rst_n(rst_n),
    .ext_pin(ext_pin),
    .change_sense_port(change_sense_port),
    .evt(evt)
  );

  ciefb_core_state_t s_q;
  ciefb_core_state_t s_d;

  // request term of one control byte, used by the next state logic only
  function automatic logic ciefb_irq_of(input ciefb_ctl_t c);
    logic any;
    any = (c.timer_overflow_flag && c.timer_overflow_irq_enable) ||
          (c.ext_pin_irq_flag && c.ext_pin_irq_enable) ||
          (c.port_change_flag && c.port_change_irq_enable);
    return c.global_irq_enable && any;
  endfunction

  always_comb begin
    s_d = s_q;
    if (ctl_wr) begin
      // writing a one to a flag sets it, as a software-made event
      s_d.ctl = ciefb_ctl_t'(ctl_wdata);
    end
    // the peripheral enable lives elsewhere; keep it reading zero
    s_d.ctl.periph_unused = 1'b0;
    // events are or-ed in after the write so a set beats a same-cycle clear
    if (timer_overflow) begin
      s_d.ctl.timer_overflow_flag = 1'b1;
    end
    if (evt.ext_edge) begin
      s_d.ctl.ext_pin_irq_flag = 1'b1;
    end
    if (evt.port_change) begin
      s_d.ctl.port_change_flag = 1'b1;
    end
    // request follows the byte the same edge, no extra cycle of lag
    s_d.irq = ciefb_irq_of(s_d.ctl);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ctl_rdata = s_q.ctl;
  assign timer_overflow_flag = s_q.ctl.timer_overflow_flag;
  assign ext_pin_irq_flag = s_q.ctl.ext_pin_irq_flag;
  assign port_change_flag = s_q.ctl.port_change_flag;
  assign irq_req = s_q.irq;

  ext_enable_gate_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_q.ctl == 8'h92) |-> irq_req)
    else $error("external flag with its enable did not request");

  ext_enable_block_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_q.ctl[`CIEFB_EXT_EN_BIT:0] == 5'h02) |-> !irq_req)
    else $error("external flag requested with its enable clear");

  ext_en_write_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ctl_wr |=> ctl_rdata[`CIEFB_EXT_EN_BIT] ==
               $past(ctl_wdata[`CIEFB_EXT_EN_BIT]))
    else $error("external enable did not take the written value");

  port_enable_gate_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_q.ctl.global_irq_enable && s_q.ctl.port_change_flag &&
     s_q.ctl.port_change_irq_enable) |-> irq_req)
    else $error("port change flag with its enable did not request");

  port_enable_block_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_q.ctl[`CIEFB_TMR_EN_BIT:0] == 6'h01) |-> !irq_req)
    else $error("port change requested with its enable clear");

  port_en_write_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ctl_wr |=> ctl_rdata[`CIEFB_PORT_EN_BIT] ==
               $past(ctl_wdata[`CIEFB_PORT_EN_BIT]))
    else $error("port change enable did not take the written value");

  timer_flag_set_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    timer_overflow |=> timer_overflow_flag)
    else $error("timer overflow did not set its flag");

  timer_flag_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (timer_overflow_flag && !ctl_wr) |=> timer_overflow_flag)
    else $error("timer flag cleared without a write");

  timer_flag_clear_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ctl_wr && !ctl_wdata[`CIEFB_TMR_FLAG_BIT] && !timer_overflow)
    |=> !timer_overflow_flag)
    else $error("writing zero did not clear the timer flag");

  ext_flag_set_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    evt.ext_edge |=> ext_pin_irq_flag)
    else $error("external edge did not set its flag");

  ext_flag_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ext_pin_irq_flag && !ctl_wr) |=> ext_pin_irq_flag)
    else $error("external flag cleared without a write");

  ext_flag_clear_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ctl_wr && !ctl_wdata[`CIEFB_EXT_FLAG_BIT] && !evt.ext_edge)
    |=> !ext_pin_irq_flag)
    else $error("writing zero did not clear the external flag");

  ext_pin_path_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ($rose(u_sense.s_q.s2[PORT_W]) && ext_edge_rising &&
     u_sense.s_q.fill == `CIEFB_FILL_DONE) |=> ##1 ext_pin_irq_flag)
    else $error("rising pin edge did not reach the external flag");

  ext_pin_fall_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ($fell(u_sense.s_q.s2[PORT_W]) && !ext_edge_rising &&
     u_sense.s_q.fill == `CIEFB_FILL_DONE) |=> ##1 ext_pin_irq_flag)
    else $error("falling pin edge did not reach the external flag");

  ext_wrong_edge_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ($rose(u_sense.s_q.s2[PORT_W]) && !ext_edge_rising)
    |=> !evt.ext_edge)
    else $error("edge of the unchosen direction was reported");

  global_gate_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !s_q.ctl.global_irq_enable |-> !irq_req)
    else $error("request raised with global enable clear");

  global_en_write_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ctl_wr |=> ctl_rdata[`CIEFB_GLOBAL_EN_BIT] ==
               $past(ctl_wdata[`CIEFB_GLOBAL_EN_BIT]))
    else $error("global enable did not take the written value");

  enables_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !ctl_wr |=> $stable(ctl_rdata[`CIEFB_GLOBAL_EN_BIT:`CIEFB_PORT_EN_BIT]))
    else $error("an enable bit changed without a write");

  timer_enable_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_q.ctl[`CIEFB_GLOBAL_EN_BIT:`CIEFB_TMR_FLAG_BIT] == 6'h29)
    |-> irq_req)
    else $error("timer flag with its enable did not request");

  timer_block_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_q.ctl == 8'h84) |-> !irq_req)
    else $error("timer flag requested with its enable clear");

  timer_en_write_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ctl_wr |=> ctl_rdata[`CIEFB_TMR_EN_BIT] ==
               $past(ctl_wdata[`CIEFB_TMR_EN_BIT]))
    else $error("timer enable did not take the written value");

  port_flag_set_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    evt.port_change |=> port_change_flag)
    else $error("port change did not set its flag");

  port_flag_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (port_change_flag && !ctl_wr) |=> port_change_flag)
    else $error("port change flag cleared without a write");

  port_flag_clear_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ctl_wr && !ctl_wdata[`CIEFB_PORT_FLAG_BIT] && !evt.port_change)
    |=> !port_change_flag)
    else $error("writing zero did not clear the port change flag");

  // end to end: an enabled pin that moved after sync reaches the flag
  port_pin_path_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (((u_sense.s_q.s2[PORT_W-1:0] ^ u_sense.s_q.prev[PORT_W-1:0]) &
      pin_change_enable_mask) != '0 &&
     u_sense.s_q.fill == `CIEFB_FILL_DONE) |=> ##1 port_change_flag)
    else $error("enabled pin change did not reach the port change flag");

  irq_follows_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ctl_wr && ctl_wdata == 8'h92 && !timer_overflow)
    |=> irq_req ##1 (irq_req || ctl_wr || $past(ctl_wr)))
    else $error("enabled external flag write did not request");

  irq_none_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ctl_rdata[`CIEFB_TMR_FLAG_BIT:0] == 3'h0) |-> !irq_req)
    else $error("request raised with no flag set");

  periph_zero_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !ctl_rdata[`CIEFB_PERIPH_EN_BIT])
    else $error("unused peripheral enable bit read as one");

endmodule

// >>> ciefb_cfg.svh
// constants of the core interrupt enable and flag bits: bit positions,
// reset value and synchroniser depth; assumes an 8-bit control byte.
// Behaviour
// - the external pin interrupt enable bit at position 4 lets that interrupt through when one and blocks it when zero.
// - the port change interrupt enable bit at position 3 lets the change interrupt through when one and suppresses it when zero.
// - the timer overflow flag at position 2 is set by each timer overflow, never cleared by hardware, and cleared by software writing zero.
// - the external interrupt flag at position 1 is set by each external pin event, stays set, and is cleared by software writing zero.
// - the global enable bit at position 7 gates every interrupt, so no request leaves while it is zero.
// - the timer overflow enable bit at position 5 pairs with the timer overflow flag to permit or block the timer interrupt.
// - the port change flag at position 0 is set when an enabled port pin changes state, the per-pin enables selecting which pins count.
`ifndef CIEFB_CFG_SVH
`define CIEFB_CFG_SVH

`define CIEFB_GLOBAL_EN_BIT 7
`define CIEFB_PERIPH_EN_BIT 6
`define CIEFB_TMR_EN_BIT 5
`define CIEFB_EXT_EN_BIT 4
`define CIEFB_PORT_EN_BIT 3
`define CIEFB_TMR_FLAG_BIT 2
`define CIEFB_EXT_FLAG_BIT 1
`define CIEFB_PORT_FLAG_BIT 0
`define CIEFB_CTL_RESET 8'h00
`define CIEFB_FILL_DONE 2'h3

`endif

// >>> ciefb_pkg.sv
// types of the core interrupt enable and flag bits
// assumes ciefb_cfg.svh supplies the bit positions
package ciefb_pkg;

  // control byte, msb first
  typedef struct packed {
    logic global_irq_enable;
    logic periph_unused;
    logic timer_overflow_irq_enable;
    logic ext_pin_irq_enable;
    logic port_change_irq_enable;
    logic timer_overflow_flag;
    logic ext_pin_irq_flag;
    logic port_change_flag;
  } ciefb_ctl_t;

  typedef struct packed {
    ciefb_ctl_t ctl;
    logic irq;
  } ciefb_core_state_t;

endpackage

// >>> ciefb_evt_if.sv
// event carrier between the pin sense logic and the flag core
// assumes both ends run on the same core clock
`timescale 1ns/1ns
interface ciefb_evt_if #(parameter int PORT_W = 8);
  logic ext_edge;
  logic port_change;
  logic edge_rising;
  logic [PORT_W-1:0] change_mask;

  modport sense (
    input edge_rising,
    input change_mask,
    output ext_edge,
    output port_change
  );
  modport core (
    output edge_rising,
    output change_mask,
    input ext_edge,
    input port_change
  );
endinterface

// >>> ciefb_sense.sv
// pin sense: synchronises the external pin and the change sense port,
// then reports an edge of the pin and any enabled port change as pulses.
// assumes pins are asynchronous to clk
`timescale 1ns/1ns
`include "ciefb_cfg.svh"
module ciefb_sense import ciefb_pkg::*; #(
  parameter int PORT_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  input wire logic ext_pin,
  input wire logic [PORT_W-1:0] change_sense_port,
  // events towards the core
  ciefb_evt_if.sense evt
);

  typedef struct packed {
    logic [PORT_W:0] s1;
    logic [PORT_W:0] s2;
    logic [PORT_W:0] prev;
    logic [1:0] fill;
    logic ext_edge;
    logic port_change;
  } ciefb_sense_state_t;

  ciefb_sense_state_t s_q;
  ciefb_sense_state_t s_d;
  logic armed;
  logic pin_now;
  logic pin_was;

  assign armed = (s_q.fill == `CIEFB_FILL_DONE);
  assign pin_now = s_q.s2[PORT_W];
  assign pin_was = s_q.prev[PORT_W];

  always_comb begin
    s_d = s_q;
    s_d.s1 = {ext_pin, change_sense_port};
    s_d.s2 = s_q.s1;
    s_d.prev = s_q.s2;
    if (!armed) begin
      s_d.fill = s_q.fill + 2'h1;
    end
    // no events until s2 and prev hold real samples, else reset fakes one
    s_d.ext_edge = armed && (evt.edge_rising ? (pin_now && !pin_was)
                                             : (!pin_now && pin_was));
    s_d.port_change = armed && |((s_q.s2[PORT_W-1:0] ^
                                   s_q.prev[PORT_W-1:0]) &
                                  evt.change_mask);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign evt.ext_edge = s_q.ext_edge;
  assign evt.port_change = s_q.port_change;

  masked_pins_quiet_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ((s_q.s2[PORT_W-1:0] ^ s_q.prev[PORT_W-1:0]) & evt.change_mask) == '0
    |=> !evt.port_change)
    else $error("port change reported for no enabled pin change");

endmodule

// >>> tb_top.sv
// self-checking bench for the core interrupt enable and flag bits
// assumes ciefb_core with PORT_W=8; drives every input 5 ns after rise
`timescale 1ns/1ns
module tb_top import ciefb_pkg::*;;
  // clock and reset
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  // control byte
  logic ctl_wr = 1'b0;
  logic [7:0] ctl_wdata = 8'h00;
  logic [7:0] ctl_rdata;
  // events and pins
  logic timer_overflow = 1'b0;
  logic ext_pin = 1'b0;
  logic ext_edge_rising = 1'b1;
  logic [7:0] change_sense_port = 8'h00;
  logic [7:0] pin_change_enable_mask = 8'h00;
  // flags and request
  logic timer_overflow_flag;
  logic ext_pin_irq_flag;
  logic port_change_flag;
  logic irq_req;
  int errors = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'h9981f342;
  logic [7:0] corner [4] = '{8'hff, 8'h40, 8'h7f, 8'h94};

  always #25 clk = ~clk;

  ciefb_core #(.PORT_W(8)) ciefb_core_i (
    .clk(clk),
    .rst_n(rst_n),
    .ctl_wr(ctl_wr),
    .ctl_wdata(ctl_wdata),
    .ctl_rdata(ctl_rdata),
    .timer_overflow(timer_overflow),
    .ext_pin(ext_pin),
    .ext_edge_rising(ext_edge_rising),
    .change_sense_port(change_sense_port),
    .pin_change_enable_mask(pin_change_enable_mask),
    .timer_overflow_flag(timer_overflow_flag),
    .ext_pin_irq_flag(ext_pin_irq_flag),
    .port_change_flag(port_change_flag),
    .irq_req(irq_req)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // request follows the byte it is registered from
  function automatic logic exp_irq(input logic [7:0] b);
    return b[7] & ((b[2] & b[5]) | (b[1] & b[4]) | (b[0] & b[3]));
  endfunction

  task automatic final_report;
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cyc;
    @(posedge clk);
    #5;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // whole visible state against the expected byte; bit6 always reads 0
  task automatic chk_st(input logic [7:0] b);
    chk({4'h0, irq_req, timer_overflow_flag, ext_pin_irq_flag,
         port_change_flag, ctl_rdata},
        {4'h0, exp_irq(b), b[2:0], b & 8'hbf});
  endtask

  // one idle edge first, so back-to-back writes never retoggle the strobe
  task automatic wr(input logic [7:0] b);
    cyc();
    ctl_wr = 1'b1;
    ctl_wdata = b;
    cyc();
    ctl_wr = 1'b0;
  endtask

  // pin events take 4 edges through the synchroniser to the flag
  task automatic wait_flag(input int idx);
    int i;
    for (i = 0; i < 8 && ctl_rdata[idx] !== 1'b1; i++) begin
      cyc();
    end
    if (i == 8) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, ctl_rdata[idx], 1'b1);
      final_report();
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    final_report();
  end

  initial begin
    #5;
    repeat (4) cyc();
    rst_n = 1'b1;
    chk_st(8'h00);
    repeat (3) cyc();
    // corner bytes first, then random bytes, back to back
    foreach (corner[k]) begin
      wr(corner[k]);
      chk_st(corner[k]);
    end
    repeat (40) begin
      seed = lfsr(seed);
      wr(seed[7:0]);
      chk_st(seed[7:0]);
    end
    // timer overflow sets and holds; set beats a same-cycle clear
    wr(8'ha0);
    timer_overflow = 1'b1;
    cyc();
    timer_overflow = 1'b0;
    chk_st(8'ha4);
    repeat (5) cyc();
    chk_st(8'ha4);
    timer_overflow = 1'b1;
    ctl_wr = 1'b1;
    ctl_wdata = 8'ha0;
    cyc();
    timer_overflow = 1'b0;
    ctl_wr = 1'b0;
    chk_st(8'ha4);
    wr(8'ha0);
    chk_st(8'ha0);
    // external pin, rising edge chosen then falling edge, global enable off first
    wr(8'h10);
    ext_pin = 1'b1;
    wait_flag(1);
    chk_st(8'h12);
    wr(8'h92);
    chk_st(8'h92);
    wr(8'h90);
    ext_pin = 1'b0;
    repeat (8) cyc();
    chk_st(8'h90);
    ext_edge_rising = 1'b0;
    ext_pin = 1'b1;
    repeat (8) cyc();
    chk_st(8'h90);
    ext_pin = 1'b0;
    wait_flag(1);
    chk_st(8'h92);
    wr(8'h80);
    chk_st(8'h80);
    // port change: masked pin ignored, enabled pin sets the flag
    wr(8'h88);
    pin_change_enable_mask = 8'h08;
    change_sense_port = 8'h04;
    repeat (8) cyc();
    chk_st(8'h88);
    change_sense_port = 8'h0c;
    wait_flag(0);
    chk_st(8'h89);
    wr(8'h81);
    chk_st(8'h81);
    wr(8'h88);
    chk_st(8'h88);
    // random mask with pin 0 forced on, then pin 0 toggled: the enabled pin sets the flag
    seed = lfsr(seed);
    pin_change_enable_mask = seed[7:0] | 8'h01;
    change_sense_port = change_sense_port ^ 8'h01;
    wait_flag(0);
    chk_st(8'h89);
    // mid-run reset with pins away from zero: state clears, and refilling
    // the synchroniser must not fake a pin edge or a port change
    ext_edge_rising = 1'b1;
    ext_pin = 1'b1;
    rst_n = 1'b0;
    repeat (2) cyc();
    chk_st(8'h00);
    rst_n = 1'b1;
    repeat (5) cyc();
    chk_st(8'h00);
    wr(8'h9a);
    chk_st(8'h9a);
    final_report();
  end
endmodule
